// File: common/tmr16_pkg.sv
package tmr16_pkg;

    localparam logic [6:0]  TMR16_OFS_IRQ   = 7'h00;
    localparam logic [6:0]  TMR16_OFS_RUN   = 7'h04;
    localparam logic [6:0]  TMR16_OFS_TC    = 7'h08;
    localparam logic [6:0]  TMR16_OFS_PRL   = 7'h0c;
    localparam logic [6:0]  TMR16_OFS_PRC   = 7'h10;
    localparam logic [6:0]  TMR16_OFS_MACT  = 7'h14;
    localparam logic [6:0]  TMR16_OFS_CMP0  = 7'h18;
    localparam logic [6:0]  TMR16_OFS_CMP1  = 7'h1c;
    localparam logic [6:0]  TMR16_OFS_CMP2  = 7'h20;
    localparam logic [6:0]  TMR16_OFS_CMP3  = 7'h24;
    localparam logic [6:0]  TMR16_OFS_CAPS  = 7'h28;
    localparam logic [6:0]  TMR16_OFS_CAPV  = 7'h2c;
    localparam logic [6:0]  TMR16_OFS_EMC   = 7'h3c;
    localparam logic [6:0]  TMR16_OFS_CSRC  = 7'h70;
    localparam logic [6:0]  TMR16_OFS_PWM   = 7'h74;

    localparam int          TMR16_RUN_EN    = 0;
    localparam int          TMR16_RUN_CLR   = 1;
    localparam int          TMR16_IRQ_CAP   = 4;
    localparam int          TMR16_NMATCH    = 4;
    localparam int          TMR16_NPINS     = 3;

    localparam logic [15:0] TMR16_RST16     = 16'h0000;
    localparam logic [4:0]  TMR16_RST_IRQ   = 5'h00;

    // Count source: 0 timer, 1 rising, 2 falling, 3 both edges of capture input
    typedef enum logic [1:0]
    {
        TMR16_SRC_TIMER = 2'h0,
        TMR16_SRC_RISE  = 2'h1,
        TMR16_SRC_FALL  = 2'h2,
        TMR16_SRC_BOTH  = 2'h3
    } tmr16_src_t;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [31:0] wdata;
    } tmr16_bus_t;

endpackage : tmr16_pkg

// File: core/tmr16_core.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Interrupt flag register shows five pending sources: four matches, one capture.
// - Writing the interrupt flag register acknowledges events.
// - Writing one clears a flag; zero leaves it; set wins over clear.
// - Run control can disable the counter and hold it reset.
// - Bit 0 enables both counters; bit 1 holds both at zero.
// - Timer count advances once every limit+1 enabled ticks (clocks in timer mode, selected capture edges in counter mode).
// - Divider count equal to limit: next enabled tick increments timer, zeroes divider.
// - Divider count is readable and writable by software.
// - Timer count wraps through 0xffff to zero, no interrupt.
// - Match action register selects interrupt and reset per match.
// - Each match may reset, stop, and interrupt, in any combination.
// - Stop on match halts counters and clears the enable bit.
// - Capture setup picks edges loading capture and capture interrupt.
// - Captured value loads timer count on selected capture input edge.
// - External match register drives compare output pins.
// - Count source register chooses timer mode or counter mode edges.
// - PWM mask enables PWM per compare output pin.
// - All used bits reset to zero.
// - Two identical instances share offsets; pin count differs.
module tmr16_core
    import tmr16_pkg::*;
#(
    // Pin count: three on the first instance, two on the second
    parameter int NPINS = TMR16_NPINS
)
(
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              ce_i,
    input  wire tmr16_bus_t        bus_i,
    output logic       [31:0]      rdata_o,
    input  wire logic              capture_input_i,
    output logic       [NPINS-1:0] compare_out_pins_o,
    output logic                   irq_o
);

    logic [4:0]  interrupt_flags_r;
    logic [1:0]  run_control_r;
    logic [15:0] timer_count_r;
    logic [15:0] divider_limit_r;
    logic [15:0] divider_count_r;
    logic [11:0] match_action_ctrl_r;
    logic [15:0] compare_value_r [TMR16_NMATCH];
    logic [2:0]  capture_setup_r;
    logic [15:0] captured_value_r;
    logic [11:0] ext_match_ctrl_r;
    logic [3:0]  count_source_ctrl_r;
    logic [3:0]  pwm_enable_mask_r;
    logic [2:0]  cap_sync_r;
    logic [31:0] rdata_r;

    // Capture pin: three stages, change counted when stage 2 and 3 agree
    logic cap_prev_r;
    logic cap_stable;
    assign cap_stable = (cap_sync_r[1] == cap_sync_r[2]) ? cap_sync_r[1] : cap_prev_r;
    wire cap_rise = cap_stable & ~cap_prev_r;
    wire cap_fall = ~cap_stable & cap_prev_r;

    wire wr_irq  = bus_i.wr && bus_i.addr == TMR16_OFS_IRQ;
    wire wr_run  = bus_i.wr && bus_i.addr == TMR16_OFS_RUN;
    wire wr_tc   = bus_i.wr && bus_i.addr == TMR16_OFS_TC;
    wire wr_prl  = bus_i.wr && bus_i.addr == TMR16_OFS_PRL;
    wire wr_prc  = bus_i.wr && bus_i.addr == TMR16_OFS_PRC;
    wire wr_mact = bus_i.wr && bus_i.addr == TMR16_OFS_MACT;
    wire wr_caps = bus_i.wr && bus_i.addr == TMR16_OFS_CAPS;
    wire wr_emc  = bus_i.wr && bus_i.addr == TMR16_OFS_EMC;
    wire wr_csrc = bus_i.wr && bus_i.addr == TMR16_OFS_CSRC;
    wire wr_pwm  = bus_i.wr && bus_i.addr == TMR16_OFS_PWM;

    // Counter mode ticks on selected capture edges, timer mode on every clock
    wire [1:0] src = count_source_ctrl_r[1:0];
    wire       tick = (src == TMR16_SRC_TIMER) ? 1'b1 :
                      (src == TMR16_SRC_RISE)  ? cap_rise :
                      (src == TMR16_SRC_FALL)  ? cap_fall : (cap_rise | cap_fall);
    wire       run_en   = run_control_r[TMR16_RUN_EN];
    wire       run_clr  = run_control_r[TMR16_RUN_CLR];
    wire       adv      = run_en && !run_clr && tick;
    wire       terminal = divider_count_r == divider_limit_r;
    wire       tc_step  = adv && terminal;

    logic [3:0] match_hit;
    logic [3:0] match_irq;
    logic [3:0] match_rst;
    logic [3:0] match_stop;
    genvar g;
    generate
        for (g = 0; g < TMR16_NMATCH; g++)
        begin : g_match
            // Match acts as the timer count moves onto the compare value
            assign match_hit[g]  = tc_step && (timer_count_r + 16'h0001) == compare_value_r[g];
            assign match_irq[g]  = match_hit[g] && match_action_ctrl_r[3*g];
            assign match_rst[g]  = match_hit[g] && match_action_ctrl_r[3*g+1];
            assign match_stop[g] = match_hit[g] && match_action_ctrl_r[3*g+2];
        end
    endgenerate

    wire cap_evt = (capture_setup_r[0] && cap_rise) || (capture_setup_r[1] && cap_fall);
    wire [4:0] irq_set = {cap_evt && capture_setup_r[2], match_irq};

    // Match outputs: EXT_MATCH_CTRL bits [NPINS-1:0] hold pin levels, action field 2 bits per pin at [4+2n]
    logic [NPINS-1:0] pin_nxt;
    always_comb
    begin
        pin_nxt = ext_match_ctrl_r[NPINS-1:0];
        for (int n = 0; n < NPINS; n++)
        begin
            if (match_hit[n])
            begin
                case (ext_match_ctrl_r[4+2*n +: 2])
                    2'h1:    pin_nxt[n] = 1'b0;
                    2'h2:    pin_nxt[n] = 1'b1;
                    2'h3:    pin_nxt[n] = ~ext_match_ctrl_r[n];
                    default: pin_nxt[n] = ext_match_ctrl_r[n];
                endcase
            end
        end
    end

    // PWM: pin low until match, high after, cleared on cycle restart (any match reset)
    logic [NPINS-1:0] pwm_lvl;
    generate
        for (g = 0; g < NPINS; g++)
        begin : g_pwm
            assign pwm_lvl[g] = timer_count_r >= compare_value_r[g];
            assign compare_out_pins_o[g] = pwm_enable_mask_r[g] ? pwm_lvl[g] : ext_match_ctrl_r[g];
        end
    endgenerate

    assign irq_o = |interrupt_flags_r;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cap_sync_r <= 3'h0;
            cap_prev_r <= 1'b0;
        end
        else if (ce_i)
        begin
            cap_sync_r <= {cap_sync_r[1:0], capture_input_i};
            cap_prev_r <= cap_stable;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            interrupt_flags_r <= TMR16_RST_IRQ;
        end
        else if (ce_i)
        begin
            interrupt_flags_r <= (interrupt_flags_r & ~(wr_irq ? bus_i.wdata[4:0] : 5'h00)) | irq_set;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            run_control_r <= 2'h0;
        end
        else if (ce_i)
        begin
            if (|match_stop)
                run_control_r[TMR16_RUN_EN] <= 1'b0;
            else if (wr_run)
                run_control_r[TMR16_RUN_EN] <= bus_i.wdata[TMR16_RUN_EN];
            if (wr_run)
                run_control_r[TMR16_RUN_CLR] <= bus_i.wdata[TMR16_RUN_CLR];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            timer_count_r   <= TMR16_RST16;
            divider_count_r <= TMR16_RST16;
        end
        else if (ce_i)
        begin
            if (run_clr)
            begin
                timer_count_r   <= TMR16_RST16;
                divider_count_r <= TMR16_RST16;
            end
            else
            begin
                if (|match_rst)
                    timer_count_r <= TMR16_RST16;
                else if (tc_step)
                    timer_count_r <= timer_count_r + 16'h0001;
                else if (wr_tc)
                    timer_count_r <= bus_i.wdata[15:0];
                if (adv)
                    divider_count_r <= terminal ? TMR16_RST16 : divider_count_r + 16'h0001;
                else if (wr_prc)
                    divider_count_r <= bus_i.wdata[15:0];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            divider_limit_r     <= TMR16_RST16;
            match_action_ctrl_r <= 12'h000;
            capture_setup_r     <= 3'h0;
            captured_value_r    <= TMR16_RST16;
            ext_match_ctrl_r    <= 12'h000;
            count_source_ctrl_r <= 4'h0;
            pwm_enable_mask_r   <= 4'h0;
            for (int i = 0; i < TMR16_NMATCH; i++)
                compare_value_r[i] <= TMR16_RST16;
        end
        else if (ce_i)
        begin
            if (wr_prl)
                divider_limit_r <= bus_i.wdata[15:0];
            if (wr_mact)
                match_action_ctrl_r <= bus_i.wdata[11:0];
            if (wr_caps)
                capture_setup_r <= bus_i.wdata[2:0];
            if (cap_evt)
                captured_value_r <= timer_count_r;
            ext_match_ctrl_r[11:4] <= wr_emc ? bus_i.wdata[11:4] : ext_match_ctrl_r[11:4];
            ext_match_ctrl_r[3:0]  <= 4'(pin_nxt);
            if (wr_emc)
                ext_match_ctrl_r[NPINS-1:0] <= bus_i.wdata[NPINS-1:0];
            if (wr_csrc)
                count_source_ctrl_r <= bus_i.wdata[3:0];
            if (wr_pwm)
                pwm_enable_mask_r <= bus_i.wdata[3:0];
            for (int i = 0; i < TMR16_NMATCH; i++)
                if (bus_i.wr && bus_i.addr == TMR16_OFS_CMP0 + 7'(4*i))
                    compare_value_r[i] <= bus_i.wdata[15:0];
        end
    end

    // Read mux; unmapped and reserved offsets read zero
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        case (bus_i.addr)
            TMR16_OFS_IRQ:  rd_mux = {27'h0, interrupt_flags_r};
            TMR16_OFS_RUN:  rd_mux = {30'h0, run_control_r};
            TMR16_OFS_TC:   rd_mux = {16'h0, timer_count_r};
            TMR16_OFS_PRL:  rd_mux = {16'h0, divider_limit_r};
            TMR16_OFS_PRC:  rd_mux = {16'h0, divider_count_r};
            TMR16_OFS_MACT: rd_mux = {20'h0, match_action_ctrl_r};
            TMR16_OFS_CMP0: rd_mux = {16'h0, compare_value_r[0]};
            TMR16_OFS_CMP1: rd_mux = {16'h0, compare_value_r[1]};
            TMR16_OFS_CMP2: rd_mux = {16'h0, compare_value_r[2]};
            TMR16_OFS_CMP3: rd_mux = {16'h0, compare_value_r[3]};
            TMR16_OFS_CAPS: rd_mux = {29'h0, capture_setup_r};
            TMR16_OFS_CAPV: rd_mux = {16'h0, captured_value_r};
            TMR16_OFS_EMC:  rd_mux = {20'h0, ext_match_ctrl_r};
            TMR16_OFS_CSRC: rd_mux = {28'h0, count_source_ctrl_r};
            TMR16_OFS_PWM:  rd_mux = {28'h0, pwm_enable_mask_r};
            default:        rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            rdata_r <= 32'h0;
        else if (ce_i && bus_i.rd)
            rdata_r <= rd_mux;
    end
    assign rdata_o = rdata_r;

    AST_CLR_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && run_clr ##1 ce_i |-> timer_count_r == 16'h0 && divider_count_r == 16'h0)
        else $error("counters not held at zero");
    AST_STOP: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && |match_stop |=> !run_control_r[TMR16_RUN_EN])
        else $error("stop on match did not clear enable");
    AST_W1C: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && wr_irq && bus_i.wdata[0] && !irq_set[0] |=> !interrupt_flags_r[0])
        else $error("flag not cleared by one");
    AST_SETWIN: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && irq_set[4] |=> interrupt_flags_r[4])
        else $error("capture flag lost");
    AST_STEP: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && tc_step && !run_clr && !(|match_rst) |=>
        timer_count_r == $past(timer_count_r) + 16'h1 && divider_count_r == 16'h0)
        else $error("terminal step wrong");
    AST_IDLE: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && !run_en && !run_clr && !wr_tc && !wr_prc |=> $stable(timer_count_r) && $stable(divider_count_r))
        else $error("counters moved while disabled");
    AST_CAP: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && cap_evt |=> captured_value_r == $past(timer_count_r))
        else $error("capture value wrong");
    AST_GAP: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && bus_i.rd && bus_i.addr >= 7'h40 && bus_i.addr <= 7'h6c |=> rdata_o == 32'h0)
        else $error("reserved gap not zero");

    // Flag, counter, capture and pin checks
    AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && |irq_set |=> (interrupt_flags_r & $past(irq_set)) == $past(irq_set))
        else $error("event flag not raised");
    AST_CAP_CLR: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && wr_irq && bus_i.wdata[TMR16_IRQ_CAP] && !irq_set[TMR16_IRQ_CAP] |=> !interrupt_flags_r[TMR16_IRQ_CAP])
        else $error("capture flag not acknowledged");
    AST_ZERO_KEEP: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && wr_irq && !bus_i.wdata[0] && interrupt_flags_r[0] |=> interrupt_flags_r[0])
        else $error("flag cleared by a zero");
    AST_EN_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && wr_run && !(|match_stop) |=> run_control_r == $past(bus_i.wdata[1:0]))
        else $error("run control write lost");
    AST_DIV_CNT: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && adv && !terminal && !wr_tc |=>
        divider_count_r == $past(divider_count_r) + 16'h1 && $stable(timer_count_r))
        else $error("divider step wrong");
    AST_READ: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && bus_i.rd && bus_i.addr == TMR16_OFS_PRC |=> rdata_o == {16'h0, $past(divider_count_r)})
        else $error("divider count read wrong");
    AST_WRAP: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && tc_step && timer_count_r == 16'hffff && !(|match_rst) |=> timer_count_r == 16'h0)
        else $error("timer count did not wrap");
    AST_MATCH_RST: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && |match_rst |=> timer_count_r == 16'h0)
        else $error("reset on match failed");
    AST_RO_CAPV: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && !cap_evt |=> $stable(captured_value_r))
        else $error("captured value changed without event");
    AST_PIN_TOGGLE: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && !wr_emc && match_hit[0] && ext_match_ctrl_r[5:4] == 2'h3 |=> ext_match_ctrl_r[0] != $past(ext_match_ctrl_r[0]))
        else $error("match pin did not toggle");
    AST_SRC_EDGE: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && src == TMR16_SRC_RISE && !run_clr && !cap_rise && !wr_tc && !wr_prc |=>
        $stable(timer_count_r) && $stable(divider_count_r))
        else $error("counter mode moved without edge");

endmodule : tmr16_core

`default_nettype wire

// File: verif/tmr16_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module tmr16_pin_model
(
    input  wire logic       clk_i,
    input  wire logic       want_i,
    input  wire logic [2:0] pins_i,
    output logic            cap_o,
    output logic [2:0]      seen_o
);
    // Pin moves and is watched on the falling edge, clear of the sampling edge
    always @(negedge clk_i)
    begin
        cap_o <= want_i;
        seen_o <= pins_i;
    end
endmodule : tmr16_pin_model

`default_nettype wire

// File: verif/tmr16_test.sv
`timescale 1ns/1ps
`default_nettype none

module tmr16_test;
    import tmr16_pkg::*;
    logic        clk_i;
    logic        reset_i;
    logic        want;
    logic        ce;
    logic        cap;
    logic        irq;
    logic [2:0]  pins;
    logic [2:0]  seen;
    logic [31:0] rdata;
    logic [31:0] d;
    tmr16_bus_t  bus;
    int          failures;
    int          tests_run;
    int          cyc = 0;

    tmr16_core #(.NPINS(3)) dut_u
    (
        .clk_i              (clk_i),
        .reset_i            (reset_i),
        .ce_i               (ce),
        .bus_i              (bus),
        .rdata_o            (rdata),
        .capture_input_i    (cap),
        .compare_out_pins_o (pins),
        .irq_o              (irq)
    );

    tmr16_pin_model pin_u
    (
        .clk_i  (clk_i),
        .want_i (want),
        .pins_i (pins),
        .cap_o  (cap),
        .seen_o (seen)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        @(negedge clk_i);
        bus = '{1'b1, 1'b0, a, v};
        @(negedge clk_i);
        bus = '0;
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [31:0] v);
        @(negedge clk_i);
        bus = '{1'b0, 1'b1, a, 32'h0};
        @(negedge clk_i);
        bus = '0;
        v = rdata;
    endtask : rd

    task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(v, exp);
    endtask : rdc

    // One high-then-low pulse on the capture pin, long enough for the synchroniser
    task automatic pulse;
        @(negedge clk_i) want <= 1'b1;
        repeat (4) @(negedge clk_i);
        want <= 1'b0;
        repeat (8) @(negedge clk_i);
    endtask : pulse

    initial
    begin
        reset_i = 1'b1;
        bus = '0;
        want = 1'b0;
        failures = 0;
        tests_run = 0;
        ce = 1'b1;
        repeat (16) @(negedge clk_i);
        reset_i = 1'b0;
        for (int i = 0; i < 32; i++)
            rdc(7'(i * 4), 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(7'h40, 32'hffffffff);
        rdc(7'h40, 32'h0);
        wr(TMR16_OFS_PRC, 32'h5);
        rdc(TMR16_OFS_PRC, 32'h5);
        wr(TMR16_OFS_PRL, 32'h3);
        rdc(TMR16_OFS_PRL, 32'h3);
        wr(TMR16_OFS_RUN, 32'h2);
        rdc(TMR16_OFS_PRC, 32'h0);
        rdc(TMR16_OFS_RUN, 32'h2);
        wr(TMR16_OFS_RUN, 32'h0);
        wr(TMR16_OFS_CMP0, 32'h5);
        wr(TMR16_OFS_MACT, 32'h5);
        wr(TMR16_OFS_RUN, 32'h1);
        repeat (40) @(negedge clk_i);
        rdc(TMR16_OFS_RUN, 32'h0);
        rdc(TMR16_OFS_TC, 32'h5);
        rdc(TMR16_OFS_PRC, 32'h0);
        rdc(TMR16_OFS_IRQ, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr(TMR16_OFS_IRQ, 32'h1e);
        rdc(TMR16_OFS_IRQ, 32'h1);
        wr(TMR16_OFS_IRQ, 32'h1);
        rdc(TMR16_OFS_IRQ, 32'h0);
        wr(TMR16_OFS_MACT, 32'h2);
        wr(TMR16_OFS_PRL, 32'h0);
        wr(TMR16_OFS_TC, 32'h0);
        wr(TMR16_OFS_RUN, 32'h1);
        repeat (30) @(negedge clk_i);
        wr(TMR16_OFS_RUN, 32'h0);
        rd(TMR16_OFS_TC, d);
        check({31'h0, d <= 32'h5}, 32'h1);
        rdc(TMR16_OFS_IRQ, 32'h0);
        wr(TMR16_OFS_MACT, 32'h0);
        wr(TMR16_OFS_TC, 32'hfffe);
        wr(TMR16_OFS_RUN, 32'h1);
        repeat (4) @(negedge clk_i);
        wr(TMR16_OFS_RUN, 32'h0);
        rd(TMR16_OFS_TC, d);
        check({31'h0, d < 32'h10}, 32'h1);
        rdc(TMR16_OFS_IRQ, 32'h0);
        wr(TMR16_OFS_TC, 32'h1234);
        wr(TMR16_OFS_CAPS, 32'h5);
        pulse();
        rdc(TMR16_OFS_CAPV, 32'h1234);
        rdc(TMR16_OFS_IRQ, 32'h10);
        wr(TMR16_OFS_CAPV, 32'h0);
        rdc(TMR16_OFS_CAPV, 32'h1234);
        wr(TMR16_OFS_IRQ, 32'h10);
        wr(TMR16_OFS_CAPS, 32'h2);
        wr(TMR16_OFS_TC, 32'h77);
        pulse();
        rdc(TMR16_OFS_CAPV, 32'h77);
        rdc(TMR16_OFS_IRQ, 32'h0);
        wr(TMR16_OFS_CAPS, 32'h0);
        // Rising, falling and both-edge counting of two pulses
        for (int m = 1; m < 4; m++)
        begin
            wr(TMR16_OFS_TC, 32'h0);
            wr(TMR16_OFS_CSRC, 32'(m));
            wr(TMR16_OFS_RUN, 32'h1);
            pulse();
            pulse();
            wr(TMR16_OFS_RUN, 32'h0);
            rdc(TMR16_OFS_TC, (m == 3) ? 32'h4 : 32'h2);
        end
        wr(TMR16_OFS_CSRC, 32'h0);
        wr(TMR16_OFS_EMC, 32'h5);
        repeat (2) @(negedge clk_i);
        check({29'h0, seen}, 32'h5);
        wr(TMR16_OFS_EMC, 32'h0);
        wr(TMR16_OFS_PWM, 32'h1);
        wr(TMR16_OFS_TC, 32'h10);
        repeat (2) @(negedge clk_i);
        check({29'h0, seen}, 32'h1);
        wr(TMR16_OFS_TC, 32'h2);
        repeat (2) @(negedge clk_i);
        check({29'h0, seen}, 32'h0);
        wr(TMR16_OFS_PWM, 32'h0);
        wr(TMR16_OFS_EMC, 32'h30);
        wr(TMR16_OFS_MACT, 32'h4);
        wr(TMR16_OFS_RUN, 32'h1);
        repeat (8) @(negedge clk_i);
        rdc(TMR16_OFS_EMC, 32'h31);
        check({29'h0, seen}, 32'h1);
        rdc(TMR16_OFS_TC, 32'h5);
        // Clock enable low freezes the running counter
        wr(TMR16_OFS_MACT, 32'h0);
        wr(TMR16_OFS_TC, 32'h0);
        wr(TMR16_OFS_RUN, 32'h1);
        ce = 1'b0;
        repeat (20) @(negedge clk_i);
        ce = 1'b1;
        wr(TMR16_OFS_RUN, 32'h0);
        rdc(TMR16_OFS_TC, 32'h2);
        print_verdict();
    end
endmodule : tmr16_test

`default_nettype wire
